// *** logic/xph_pkg.sv ***
// package for the crosspoint host controller: software map, pin timing, states
// assumes a 200 MHz system clock and the crosspoint pins wired straight to the top module
package xph_pkg;
	// ****************************************
	// software register map (byte offsets)
	// ****************************************
	localparam logic [3:0] OFS_STAGE  = 4'h0; // address and data staged for the next command
	localparam logic [3:0] OFS_CMD    = 4'h4; // write one to start a pin operation
	localparam logic [3:0] OFS_STATUS = 4'h8; // busy, readback, error flags

	// stage register fields
	localparam int STG_ADDR_LSB = 0;  // seven address lines, top bit is bank_pick_bit
	localparam int STG_DATA_LSB = 8;  // six data lines

	// command register bits, highest listed first in priority
	localparam int CMD_RESET  = 3;
	localparam int CMD_READ   = 2;
	localparam int CMD_UPDATE = 1;
	localparam int CMD_WRITE  = 0;

	// status register fields
	localparam int ST_BUSY     = 0;
	localparam int ST_RB_VALID = 1;
	localparam int ST_ALL_PROG = 2;
	localparam int ST_ERR_LSB  = 3; // busy-refused, broadcast-read, reserved-address
	localparam int ST_RB_LSB   = 8;

	// ****************************************
	// device codes
	// ****************************************
	localparam int          NUM_OUTPUTS  = 34;
	localparam logic [5:0]  BCAST_CODE   = 6'h3f; // broadcast address and disable data
	localparam logic [3:0]  CUR_DEFAULT  = 4'h7;  // current_level_code after device reset

	// ****************************************
	// pin timing
	// ****************************************
	localparam int CLK_PERIOD_NS  = 5;
	localparam int T_PULSE_MIN_NS = 10; // least strobe and reset width
	localparam int T_RD_ACC_NS    = 30; // longest data valid after read strobe
	localparam int T_ADDR_HOLD_NS = 5;  // address held after read strobe
	localparam int SYNC_STAGES    = 2;
	localparam int PULSE_CYC  = (T_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RD_ACC_CYC = (T_RD_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_CYC   = (T_ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RD_LOW_CYC = RD_ACC_CYC + SYNC_STAGES + 1;
	localparam int CNT_W      = 4;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_SETUP   = 2'b01,
		ST_ACTIVE  = 2'b11,
		ST_RECOVER = 2'b10
	} xph_state_t;

	typedef enum logic [1:0] {
		OP_WRITE  = 2'b00,
		OP_UPDATE = 2'b01,
		OP_READ   = 2'b10,
		OP_RESET  = 2'b11
	} xph_op_t;
endpackage

// *** logic/xph_sync.sv ***
// two-flop synchroniser for a bundle of pin inputs
// assumes each bit is quasi-static while sampled; no bus-wide coherence is promised
`timescale 1ns/10ps
module xph_sync #(
	parameter int WIDTH = 6
) (
	input  wire logic             sys_clk,
	input  wire logic             nrst,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	// a bundle of no bits has nothing to carry
	if (WIDTH < 1) begin : g_bad_width
		$error("WIDTH must be at least 1");
	end

	// ****************************************
	// per-bit two-stage chain
	// ****************************************
	generate
		for (genvar i = 0; i < WIDTH; i++) begin : g_bit
			logic meta_reg;
			logic meta_next;
			logic sync_reg;
			logic sync_next;
			// first flop feeds only the second
			always_comb begin
				meta_next = din[i];
				sync_next = meta_reg;
			end
			always_ff @(posedge sys_clk or negedge nrst) begin
				if (!nrst) begin
					meta_reg <= 1'b0;
					sync_reg <= 1'b0;
				end else begin
					meta_reg <= meta_next;
					sync_reg <= sync_next;
				end
			end
			assign dout[i] = sync_reg;
		end
	endgenerate
endmodule // xph_sync

// *** logic/xph_host.sv ***
// host controller driving the dual-rank crosspoint control port pins
// assumes software on a plain strobe port, device pins wired directly, 200 MHz sys_clk
`timescale 1ns/10ps
module xph_host
	import xph_pkg::*;
#(
	parameter int NUM_OUT = NUM_OUTPUTS
) (
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic [3:0]  bus_addr,
	input  wire logic [31:0] bus_wdata,
	input  wire logic        bus_wr,
	input  wire logic        bus_rd,
	output logic      [31:0] bus_rdata,
	output logic      [6:0]  xp_addr,
	output logic      [5:0]  xp_data_o,
	output logic             xp_data_oe,
	input  wire logic [5:0]  xp_data_i,
	output logic             xp_cs_n,
	output logic             xp_wr_n,
	output logic             xp_upd_n,
	output logic             rank2_fetch_n,
	output logic             xp_rst_n
);
	// ****************************************
	// elaboration checks
	// ****************************************
	if (NUM_OUT < 1 || NUM_OUT > 63) begin : g_bad_num
		$error("NUM_OUT must lie in 1..63");
	end
	if (RD_LOW_CYC >= (1 << CNT_W)) begin : g_bad_cnt
		$error("strobe counter too narrow");
	end

	localparam logic [5:0] LAST_OUT = 6'(NUM_OUT - 1);

	// ****************************************
	// state
	// ****************************************
	xph_state_t          state_reg, state_next;
	xph_op_t             op_reg, op_next;
	logic [CNT_W-1:0]    cnt_reg, cnt_next;
	logic [6:0]          stg_addr_reg, stg_addr_next;
	logic [5:0]          stg_data_reg, stg_data_next;
	logic [6:0]          pa_reg, pa_next;
	logic [5:0]          pd_reg, pd_next;
	logic                oe_reg, oe_next;
	logic                cs_n_reg, cs_n_next;
	logic                wr_n_reg, wr_n_next;
	logic                upd_n_reg, upd_n_next;
	logic                fetch_n_reg, fetch_n_next;
	logic                rst_n_reg, rst_n_next;
	logic [5:0]          rb_reg, rb_next;
	logic                rb_valid_reg, rb_valid_next;
	logic [2:0]          err_reg, err_next;
	logic                boot_reg, boot_next;
	logic [NUM_OUT-1:0]  prog_reg, prog_next;
	logic [31:0]         rdata_reg, rdata_next;
	logic [5:0]          rb_sync;
	logic [2:0]          err_set;
	logic                busy;
	logic [5:0]          out_sel;
	logic                out_rsvd;

	// pin readback passes two flops before use
	xph_sync #(
		.WIDTH (6)
	) u_sync (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.din     (xp_data_i),
		.dout    (rb_sync)
	);

	assign busy     = (state_reg != ST_IDLE) || boot_reg;
	assign out_sel  = stg_addr_reg[5:0];
	assign out_rsvd = (out_sel > LAST_OUT) && (out_sel != BCAST_CODE);

	// ****************************************
	// next-state logic
	// ****************************************
	always_comb begin
		state_next    = state_reg;
		op_next       = op_reg;
		cnt_next      = cnt_reg;
		stg_addr_next = stg_addr_reg;
		stg_data_next = stg_data_reg;
		pa_next       = pa_reg;
		pd_next       = pd_reg;
		oe_next       = oe_reg;
		cs_n_next     = cs_n_reg;
		wr_n_next     = wr_n_reg;
		upd_n_next    = upd_n_reg;
		fetch_n_next  = fetch_n_reg;
		rst_n_next    = rst_n_reg;
		rb_next       = rb_reg;
		rb_valid_next = rb_valid_reg;
		boot_next     = boot_reg;
		prog_next     = prog_reg;
		err_set       = 3'h0;
		rdata_next    = 32'h0;

		// software stage register is writable at any time; pins use a launch copy
		if (bus_wr && bus_addr == OFS_STAGE) begin
			stg_addr_next = bus_wdata[STG_ADDR_LSB +: 7];
			stg_data_next = bus_wdata[STG_DATA_LSB +: 6];
		end

		// ****************************************
		// command launch
		// ****************************************
		if (state_reg == ST_IDLE && boot_reg) begin
			op_next    = OP_RESET; // power-up pulse before anything else
			state_next = ST_SETUP;
		end else if (bus_wr && bus_addr == OFS_CMD && bus_wdata[3:0] != 4'h0) begin
			if (busy) begin
				err_set[0] = 1'b1; // one operation at a time, never two strobes
			end else if (bus_wdata[CMD_RESET]) begin
				op_next    = OP_RESET;
				state_next = ST_SETUP;
			end else if (bus_wdata[CMD_READ]) begin
				if (out_sel == BCAST_CODE) begin
					err_set[1] = 1'b1; // broadcast readback refused
				end else if (out_rsvd) begin
					err_set[2] = 1'b1; // reserved output has no defined value
				end else begin
					op_next       = OP_READ;
					state_next    = ST_SETUP;
					rb_valid_next = 1'b0;
				end
			end else if (bus_wdata[CMD_UPDATE]) begin
				op_next    = OP_UPDATE;
				state_next = ST_SETUP;
			end else if (out_rsvd) begin
				err_set[2] = 1'b1;
			end else begin
				op_next    = OP_WRITE;
				state_next = ST_SETUP;
			end
			if (state_next == ST_SETUP) begin
				pa_next   = stg_addr_reg;
				pd_next   = stg_data_reg;
				cs_n_next = (op_next == OP_RESET); // reset needs no select
				oe_next   = (op_next == OP_WRITE); // read leaves data lines released
			end
		end

		// ****************************************
		// pin sequencing
		// ****************************************
		case (state_reg)
			ST_IDLE: begin
				cnt_next = '0;
			end
			ST_SETUP: begin
				// address, data and select settled one cycle before the strobe
				case (op_reg)
					OP_WRITE:  wr_n_next    = 1'b0;
					OP_UPDATE: upd_n_next   = 1'b0;
					OP_READ:   fetch_n_next = 1'b0;
					default:   rst_n_next   = 1'b0;
				endcase
				cnt_next   = '0;
				state_next = ST_ACTIVE;
			end
			ST_ACTIVE: begin
				// level-held strobe; width counted, not edge timed
				cnt_next = cnt_reg + 1'b1;
				if (cnt_reg == CNT_W'((op_reg == OP_READ ? RD_LOW_CYC : PULSE_CYC) - 1)) begin
					if (op_reg == OP_READ) begin
						rb_next       = rb_sync;
						rb_valid_next = 1'b1;
					end
					if (op_reg == OP_WRITE && !pa_reg[6]) begin
						// track connection-bank coverage for first update
						if (pa_reg[5:0] == BCAST_CODE) begin
							prog_next = '1;
						end else begin
							prog_next[pa_reg[5:0]] = 1'b1;
						end
					end
					if (op_reg == OP_RESET) begin
						prog_next = '0;
						boot_next = 1'b0;
					end
					wr_n_next    = 1'b1; // strobe returned high after the write
					upd_n_next   = 1'b1;
					fetch_n_next = 1'b1;
					rst_n_next   = 1'b1;
					cnt_next     = '0;
					state_next   = ST_RECOVER;
				end
			end
			ST_RECOVER: begin
				// address and select held past the strobe rise
				cnt_next = cnt_reg + 1'b1;
				if (cnt_reg == CNT_W'(HOLD_CYC - 1)) begin
					cs_n_next  = 1'b1;
					oe_next    = 1'b0;
					cnt_next   = '0;
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase

		// sticky errors: set wins over a software clear in the same cycle
		err_next = err_reg;
		if (bus_wr && bus_addr == OFS_STATUS) begin
			err_next = err_reg & ~bus_wdata[ST_ERR_LSB +: 3];
		end
		err_next = err_next | err_set;

		// ****************************************
		// software reads, data valid next cycle only
		// ****************************************
		if (bus_rd) begin
			case (bus_addr)
				OFS_STAGE: begin
					rdata_next[STG_ADDR_LSB +: 7] = stg_addr_reg;
					rdata_next[STG_DATA_LSB +: 6] = stg_data_reg;
				end
				OFS_STATUS: begin
					rdata_next[ST_BUSY]          = busy;
					rdata_next[ST_RB_VALID]      = rb_valid_reg;
					rdata_next[ST_ALL_PROG]      = &prog_reg;
					rdata_next[ST_ERR_LSB +: 3]  = err_reg;
					rdata_next[ST_RB_LSB +: 6]   = rb_reg;
				end
				default: begin
					rdata_next = 32'h0;
				end
			endcase
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg    <= ST_IDLE;
			op_reg       <= OP_WRITE;
			cnt_reg      <= '0;
			stg_addr_reg <= 7'h00;
			stg_data_reg <= 6'h00;
			pa_reg       <= 7'h00;
			pd_reg       <= 6'h00;
			oe_reg       <= 1'b0;
			cs_n_reg     <= 1'b1;
			wr_n_reg     <= 1'b1;
			upd_n_reg    <= 1'b1;
			fetch_n_reg  <= 1'b1;
			rst_n_reg    <= 1'b0; // device held in reset while host is
			rb_reg       <= 6'h00;
			rb_valid_reg <= 1'b0;
			err_reg      <= 3'h0;
			boot_reg     <= 1'b1;
			prog_reg     <= '0;
			rdata_reg    <= 32'h0;
		end else begin
			state_reg    <= state_next;
			op_reg       <= op_next;
			cnt_reg      <= cnt_next;
			stg_addr_reg <= stg_addr_next;
			stg_data_reg <= stg_data_next;
			pa_reg       <= pa_next;
			pd_reg       <= pd_next;
			oe_reg       <= oe_next;
			cs_n_reg     <= cs_n_next;
			wr_n_reg     <= wr_n_next;
			upd_n_reg    <= upd_n_next;
			fetch_n_reg  <= fetch_n_next;
			rst_n_reg    <= rst_n_next;
			rb_reg       <= rb_next;
			rb_valid_reg <= rb_valid_next;
			err_reg      <= err_next;
			boot_reg     <= boot_next;
			prog_reg     <= prog_next;
			rdata_reg    <= rdata_next;
		end
	end

	// all pins straight from flops
	assign bus_rdata     = rdata_reg;
	assign xp_addr       = pa_reg;   // bank_pick_bit is bit 6
	assign xp_data_o     = pd_reg;   // connection code or current_level_code
	assign xp_data_oe    = oe_reg;
	assign xp_cs_n       = cs_n_reg;
	assign xp_wr_n       = wr_n_reg;
	assign xp_upd_n      = upd_n_reg;
	assign rank2_fetch_n = fetch_n_reg;
	assign xp_rst_n      = rst_n_reg;
endmodule // xph_host

// *** dv/xph_dev_model.sv ***
// behavioural crosspoint control port: two latch ranks behind level pins
// assumes the host pins wired straight here; the data wire is resolved here
`timescale 1ns/10ps
module xph_dev_model (
	input  wire logic [6:0] xp_addr,
	input  wire logic [5:0] xp_data_o,
	input  wire logic       xp_data_oe,
	output logic      [5:0] xp_data_i,
	input  wire logic       xp_cs_n,
	input  wire logic       xp_wr_n,
	input  wire logic       xp_upd_n,
	input  wire logic       rank2_fetch_n,
	input  wire logic       xp_rst_n
);
	logic [5:0] r1c [34];
	logic [5:0] r2c [34];
	logic [5:0] r1i [34];
	logic [5:0] r2i [34];
	logic [5:0] last_d = 6'h00;

	// wire level; undriven data flips every ns so a stale value never passes
	always @* begin
		if (xp_data_oe)
			xp_data_i = xp_data_o;
		else if (!xp_cs_n && !rank2_fetch_n && xp_addr[5:0] < 6'd34)
			xp_data_i = xp_addr[6] ? r2i[xp_addr[5:0]] : r2c[xp_addr[5:0]];
		else
			xp_data_i = ~last_d;
	end

	// polled every ns: a held strobe keeps its latch open
	always #1 begin
		last_d = xp_data_i;
		for (int i = 0; i < 34; i++) begin
			if (!xp_rst_n) begin
				r1c[i] = 6'h3f;
				r2c[i] = 6'h3f;
				r1i[i] = 6'h07;
				r2i[i] = 6'h07;
			end else if (!xp_cs_n) begin
				// readback blocks writes; reserved codes hit no row
				if (!xp_wr_n && rank2_fetch_n && (xp_addr[5:0] == i || xp_addr[5:0] == 6'h3f)) begin
					if (xp_addr[6])
						r1i[i] = {2'b00, xp_data_i[3:0]};
					else
						r1c[i] = xp_data_i;
				end
				if (!xp_upd_n) begin
					r2c[i] = r1c[i];
					r2i[i] = r1i[i];
				end
			end
		end
	end
endmodule // xph_dev_model

// *** dv/xph_host_monitor.sv ***
// checker on the crosspoint host controller ports
// assumes one clock domain; bound to every xph_host instance
`timescale 1ns/10ps
module xph_host_chk
	import xph_pkg::*;
#(
	parameter int NUM_OUT = NUM_OUTPUTS
) (
	input wire logic        sys_clk,
	input wire logic        nrst,
	input wire logic [3:0]  bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic        bus_wr,
	input wire logic        bus_rd,
	input wire logic [31:0] bus_rdata,
	input wire logic [6:0]  xp_addr,
	input wire logic [5:0]  xp_data_o,
	input wire logic        xp_data_oe,
	input wire logic [5:0]  xp_data_i,
	input wire logic        xp_cs_n,
	input wire logic        xp_wr_n,
	input wire logic        xp_upd_n,
	input wire logic        rank2_fetch_n,
	input wire logic        xp_rst_n
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// ****************************************
	// pin protocol and bus read data
	// ****************************************
	chk_wr_release: assert property ($fell(xp_wr_n) |-> ##1 !xp_wr_n ##1 xp_wr_n)
		else $error("write strobe width wrong");
	chk_wr_qual: assert property (!xp_wr_n |-> xp_data_oe && !xp_cs_n && $stable(xp_addr))
		else $error("write strobe without select");
	chk_wr_hold: assert property ($rose(xp_wr_n) |-> !xp_cs_n && $stable(xp_data_o))
		else $error("write data not held");
	chk_fetch_free: assert property (!rank2_fetch_n |-> !xp_data_oe && !xp_cs_n)
		else $error("data driven in readback");
	chk_no_bcast_rd: assert property (!rank2_fetch_n |-> xp_addr[5:0] != BCAST_CODE)
		else $error("broadcast readback");
	chk_fetch_width: assert property ($fell(rank2_fetch_n) |-> ##8 !rank2_fetch_n ##1 rank2_fetch_n)
		else $error("readback strobe width wrong");
	chk_fetch_hold: assert property ($rose(rank2_fetch_n) |-> $stable(xp_addr) && !xp_cs_n)
		else $error("readback address not held");
	chk_upd_pulse: assert property ($fell(xp_upd_n) |-> !xp_cs_n ##1 !xp_upd_n ##1 xp_upd_n)
		else $error("update pulse wrong");
	chk_one_strobe: assert property ($onehot0({!xp_wr_n, !xp_upd_n, !rank2_fetch_n, !xp_rst_n}))
		else $error("strobes overlap");
	chk_rst_boot: assert property ($rose(nrst) |-> !xp_rst_n ##1 !xp_rst_n ##[1:5] xp_rst_n)
		else $error("boot reset pulse wrong");
	chk_rst_width: assert property ($fell(xp_rst_n) |-> xp_cs_n ##1 !xp_rst_n)
		else $error("reset pulse too short");
	chk_rsv_addr: assert property (!xp_wr_n |-> xp_addr[5:0] < NUM_OUT || xp_addr[5:0] == BCAST_CODE)
		else $error("write to reserved address");
	chk_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 32'h0)
		else $error("read data outside its cycle");
	cov_fetch: cover property ($rose(rank2_fetch_n));
endmodule // xph_host_chk

bind xph_host xph_host_chk #(.NUM_OUT(NUM_OUT)) i_xph_host_chk (.*);

// *** dv/testbench.sv ***
// self-checking bench: host controller driving the behavioural device
// assumes the xph_pkg map and a 200 MHz clock
`timescale 1ns/10ps
module testbench;
	import xph_pkg::*;
	logic        sys_clk = 0;
	logic        nrst = 0;
	logic [3:0]  bus_addr = 4'h0;
	logic [31:0] bus_wdata = 32'h0;
	logic        bus_wr = 0;
	logic        bus_rd = 0;
	logic [31:0] bus_rdata, st;
	logic [6:0]  xp_addr;
	logic [5:0]  xp_data_o, xp_data_i;
	logic        xp_data_oe, xp_cs_n, xp_wr_n, xp_upd_n, rank2_fetch_n, xp_rst_n;
	int          errors = 0;
	int          n_compared = 0;
	int          seed = 40;
	int          a, b, d;
	int          m1 [2][34]; // expected first rank [bank][output]
	int          m2 [2][34]; // expected second rank

	xph_host i_xph_host (.*);
	xph_dev_model i_xph_dev_model (.*);

	initial forever #2.5 sys_clk = ~sys_clk;

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one-cycle bus cycles, entered just after a rising edge
	task automatic bw(input logic [3:0] ad, input logic [31:0] wd);
		bus_addr <= ad;
		bus_wdata <= wd;
		bus_wr <= 1'b1;
		@(posedge sys_clk);
		bus_wr <= 1'b0;
		@(posedge sys_clk); // gap so bus_wr is never driven twice in one step
	endtask
	task automatic rs(input logic [3:0] ad);
		bus_addr <= ad;
		bus_rd <= 1'b1;
		@(posedge sys_clk);
		bus_rd <= 1'b0;
		#1;
		st = bus_rdata;
		@(posedge sys_clk);
	endtask
	// bounded wait for busy to drop
	task automatic idle();
		int k;
		k = 0;
		rs(OFS_STATUS);
		while (st[ST_BUSY] !== 1'b0 && k < 60) begin
			rs(OFS_STATUS);
			k++;
		end
		if (st[ST_BUSY] !== 1'b0) begin
			errors++;
			$display("wrong value busy expected 0 seen %b", st[ST_BUSY]);
		end
	endtask
	task automatic op(input int cb, input logic [6:0] ad, input logic [5:0] dd);
		bw(OFS_STAGE, {18'h0, dd, 1'b0, ad});
		bw(OFS_CMD, 32'h1 << cb);
		idle();
	endtask
	task automatic mwr(input int bk, input int ad, input int dd);
		for (int i = 0; i < 34; i++)
			if (ad == 63 || ad == i) m1[bk][i] = bk ? (dd & 15) : dd;
	endtask
	task automatic mrst();
		for (int i = 0; i < 34; i++) begin
			m1[0][i] = 63;
			m1[1][i] = 7;
		end
		m2 = m1;
	endtask
	task automatic cmp_dev();
		for (int i = 0; i < 34; i++) begin
			chk("connection", m2[0][i], {26'h0, i_xph_dev_model.r2c[i]});
			chk("current", m2[1][i], {26'h0, i_xph_dev_model.r2i[i]});
		end
	endtask
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// watchdog: the sequence needs only a few hundred cycles
	initial begin
		#100000;
		errors++;
		$display("wrong value watchdog expected done seen timeout");
		test_done();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		mrst();
		idle();
		cmp_dev();
		chk("all programmed", 0, st[ST_ALL_PROG]);
		op(CMD_WRITE, 7'h3f, 6'h0c);
		mwr(0, 63, 12);
		op(CMD_WRITE, 7'h7f, 6'h35);
		mwr(1, 63, 6'h35);
		chk("all programmed", 1, st[ST_ALL_PROG]);
		for (int n = 0; n < 24; n++) begin
			b = $random(seed) & 1;
			a = (n % 6 == 5) ? 33 : ($random(seed) & 63) % 34;
			d = ($random(seed) & 63) % 35;
			if (b == 0 && d == 34) d = 63;
			op(CMD_WRITE, {b[0], a[5:0]}, d[5:0]);
			mwr(b, a, d);
		end
		cmp_dev();
		op(CMD_UPDATE, 7'h00, 6'h00);
		m2 = m1;
		cmp_dev();
		// readback after a pending first-rank write still shows rank two
		for (int n = 0; n < 6; n++) begin
			b = n & 1;
			a = (n == 5) ? 0 : ($random(seed) & 63) % 34;
			op(CMD_WRITE, {b[0], a[5:0]}, 6'h02);
			mwr(b, a, 2);
			op(CMD_READ, {b[0], a[5:0]}, 6'h00);
			chk("readback", m2[b][a], {26'h0, st[ST_RB_LSB +: 6]});
			chk("readback valid", 1, st[ST_RB_VALID]);
		end
		op(CMD_WRITE, 7'h28, 6'h01);
		chk("reserved flag", 1, st[ST_ERR_LSB + 2]);
		op(CMD_READ, 7'h3f, 6'h00);
		chk("broadcast read flag", 1, st[ST_ERR_LSB + 1]);
		bw(OFS_STATUS, 32'h38);
		bw(OFS_STAGE, 32'h0000_0300);
		rs(OFS_STAGE);
		chk("stage readback", 32'h0000_0300, st);
		bw(OFS_CMD, 32'h1);
		bw(OFS_CMD, 32'h1);
		idle();
		mwr(0, 0, 3);
		chk("busy refusal flag", 3'b001, st[ST_ERR_LSB +: 3]);
		op(CMD_UPDATE, 7'h00, 6'h00);
		m2 = m1;
		cmp_dev();
		op(CMD_RESET, 7'h00, 6'h00);
		mrst();
		cmp_dev();
		op(CMD_UPDATE, 7'h00, 6'h00);
		cmp_dev();
		// leave a visible setting so the mid-run reset has something to undo
		op(CMD_WRITE, 7'h05, 6'h09);
		mwr(0, 5, 9);
		op(CMD_UPDATE, 7'h00, 6'h00);
		m2 = m1;
		cmp_dev();
		nrst <= 1'b0;
		@(posedge sys_clk);
		nrst <= 1'b1;
		mrst();
		idle();
		cmp_dev();
		chk("all programmed", 0, st[ST_ALL_PROG]);
		test_done();
	end
endmodule // testbench
